//--- logic/ipbu_top.sv
// Upper interrupt priority register bank behind an APB slave
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "ipbu_cfg.svh"
module ipbu_top (
    input  wire logic                      clk_sys,
    input  wire logic                      srst,
    // APB slave port
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [`IPBU_ADDR_W-1:0]   paddr,
    input  wire logic [31:0]               pwdata,
    input  wire logic [3:0]                pstrb,
    output var  ipbu_pkg::ipbu_word_t      prdata,
    output logic                           pready,
    output logic                           pslverr,
    // Flag-and-enable per source, from same-clock peripheral logic
    input  wire ipbu_pkg::ipbu_src_vec_t   src_pending,
    // Pending and not disabled, toward arbitration
    output var  ipbu_pkg::ipbu_src_vec_t   src_request,
    // Priority levels toward arbitration
    output var  ipbu_pkg::ipbu_prio_t      timer6_prio,
    output var  ipbu_pkg::ipbu_prio_t      dma_ch4_done_prio,
    output var  ipbu_pkg::ipbu_prio_t      out_cmp8_prio,
    output var  ipbu_pkg::ipbu_prio_t      timer8_prio,
    output var  ipbu_pkg::ipbu_prio_t      i2c_b_master_prio,
    output var  ipbu_pkg::ipbu_prio_t      i2c_b_slave_prio,
    output var  ipbu_pkg::ipbu_prio_t      timer7_prio,
    output var  ipbu_pkg::ipbu_prio_t      can_b_rx_ready_prio,
    output var  ipbu_pkg::ipbu_prio_t      ext_irq4_prio,
    output var  ipbu_pkg::ipbu_prio_t      ext_irq3_prio,
    output var  ipbu_pkg::ipbu_prio_t      timer9_prio,
    output var  ipbu_pkg::ipbu_prio_t      codec_port_error_prio,
    output var  ipbu_pkg::ipbu_prio_t      quad_decoder_prio,
    output var  ipbu_pkg::ipbu_prio_t      motor_pwm_prio,
    output var  ipbu_pkg::ipbu_prio_t      can_b_event_prio,
    output var  ipbu_pkg::ipbu_prio_t      pwm_fault_a_prio,
    output var  ipbu_pkg::ipbu_prio_t      dma_ch5_done_prio,
    output var  ipbu_pkg::ipbu_prio_t      codec_port_event_prio,
    output var  ipbu_pkg::ipbu_prio_t      uart_b_error_prio,
    output var  ipbu_pkg::ipbu_prio_t      uart_a_error_prio,
    output var  ipbu_pkg::ipbu_prio_t      pwm_fault_b_prio
);
    import ipbu_pkg::*;

    localparam int NSRC = `IPBU_NUM_SRC;

    // Owning register of each source, in src_pending bit order
    localparam logic [2:0] SRC_REG [NSRC] = '{
        `IPBU_IDX_11, `IPBU_IDX_11, `IPBU_IDX_11,                 // R6
        `IPBU_IDX_12, `IPBU_IDX_12, `IPBU_IDX_12, `IPBU_IDX_12,   // R7
        `IPBU_IDX_13, `IPBU_IDX_13, `IPBU_IDX_13, `IPBU_IDX_13,   // R8
        `IPBU_IDX_14, `IPBU_IDX_14, `IPBU_IDX_14, `IPBU_IDX_14,   // R9
        `IPBU_IDX_15, `IPBU_IDX_15, `IPBU_IDX_15,                 // R10
        `IPBU_IDX_16, `IPBU_IDX_16, `IPBU_IDX_16                  // R11
    };

    // Low bit of each field inside its register
    localparam int SRC_LSB [NSRC] = '{
        `IPBU_LSB_F3, `IPBU_LSB_F2, `IPBU_LSB_F0,                 // R6
        `IPBU_LSB_F3, `IPBU_LSB_F2, `IPBU_LSB_F1, `IPBU_LSB_F0,   // R7
        `IPBU_LSB_F3, `IPBU_LSB_F2, `IPBU_LSB_F1, `IPBU_LSB_F0,   // R8
        `IPBU_LSB_F3, `IPBU_LSB_F2, `IPBU_LSB_F1, `IPBU_LSB_F0,   // R9
        `IPBU_LSB_F3, `IPBU_LSB_F1, `IPBU_LSB_F0,                 // R10
        `IPBU_LSB_F2, `IPBU_LSB_F1, `IPBU_LSB_F0                  // R11
    };

    ipbu_regbus_if rbus ();

    ipbu_prio_t    level [NSRC];
    ipbu_src_vec_t req;
    logic [15:0]   next_word;

    // Bus front end
    ipbu_apb_slave u_apb (
        .clk_sys (clk_sys),
        .srst    (srst),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .pstrb   (pstrb),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .rbus    (rbus.slave)
    );

    // One field per source; a byte strobe covers the fields in its lane
    for (genvar i = 0; i < NSRC; i++) begin : g_field
        localparam int LANE = (SRC_LSB[i] >= `IPBU_LSB_F2) ? `IPBU_BYTE_HI : `IPBU_BYTE_LO;
        logic fld_wr;

        // Only field bits are stored; unused bits have no flop to disturb
        assign fld_wr = rbus.wr_stb && (rbus.idx == SRC_REG[i]) && rbus.wstrb[LANE]; // R12 R14

        ipbu_prio_field u_fld (
            .clk_sys (clk_sys),
            .srst    (srst),
            .wr_en   (fld_wr),
            .wr_val  (rbus.wdata[SRC_LSB[i] +: 3]),
            .pending (src_pending[i]),
            .level   (level[i]),
            .request (req[i])
        );
    end

    // Gated requests go out with no extra stage, so a write steers the very next cycle
    assign src_request = req; // R3 R15

    // Read word assembly; bits not owned by a field stay zero
    always_comb begin
        next_word = 16'h0000; // R5
        for (int i = 0; i < NSRC; i++) begin
            if (rbus.idx == SRC_REG[i]) begin
                next_word[SRC_LSB[i] +: 3] = level[i]; // R12
            end
        end
    end

    // Status word shows live requests; priority words show the fields
    assign rbus.rdata = (rbus.idx == `IPBU_IDX_STAT) ? {11'h000, req} : {16'h0000, next_word};

    // Named field outputs, straight from the field flops
    assign timer6_prio           = level[0];  // R6 R15
    assign dma_ch4_done_prio     = level[1];  // R6
    assign out_cmp8_prio         = level[2];  // R6
    assign timer8_prio           = level[3];  // R7
    assign i2c_b_master_prio     = level[4];  // R7
    assign i2c_b_slave_prio      = level[5];  // R7
    assign timer7_prio           = level[6];  // R7
    assign can_b_rx_ready_prio   = level[7];  // R8
    assign ext_irq4_prio         = level[8];  // R8
    assign ext_irq3_prio         = level[9];  // R8
    assign timer9_prio           = level[10]; // R8
    assign codec_port_error_prio = level[11]; // R9
    assign quad_decoder_prio     = level[12]; // R9
    assign motor_pwm_prio        = level[13]; // R9
    assign can_b_event_prio      = level[14]; // R9
    assign pwm_fault_a_prio      = level[15]; // R10
    assign dma_ch5_done_prio     = level[16]; // R10
    assign codec_port_event_prio = level[17]; // R10
    assign uart_b_error_prio     = level[18]; // R11
    assign uart_a_error_prio     = level[19]; // R11
    assign pwm_fault_b_prio      = level[20]; // R11
endmodule : ipbu_top
`default_nettype wire

//--- logic/ipbu_cfg.svh
// Register map, field layout and reset constants of the upper priority bank
// Function
// R1: Field code 111 gives its source priority 7, the highest a user source can have.
// R2: Field code 001 gives priority 1, and the codes in between map one to one onto levels 2 to 6.
// R3: Field code 000 disables the source, so it never requests service whatever its flag or enable.
// R4: At reset every field loads its upper bit as one and its two lower bits as zero.
// R5: Every bit outside a field, bit 15 of each register included, reads as zero.
// R6: Register 11 holds timer 6 in 14-12, DMA 4 done in 10-8 and output compare 8 in 2-0, bits 7-3 unused.
// R7: Register 12 holds timer 8 in 14-12, I2C B master in 10-8, I2C B slave in 6-4 and timer 7 in 2-0.
// R8: Register 13 holds CAN B receive in 14-12, ext irq 4 in 10-8, ext irq 3 in 6-4 and timer 9 in 2-0.
// R9: Register 14 holds codec error in 14-12, quad decoder in 10-8, motor PWM in 6-4 and CAN B event in 2-0.
// R10: Register 15 holds PWM fault A in 14-12, bits 11-7 unused, DMA 5 done in 6-4 and codec event in 2-0.
// R11: Register 16 leaves 15-11 unused and holds UART B error in 10-8, UART A error in 6-4, fault B in 2-0.
// R12: Every field bit is readable and writable and reads back the last write or its reset value.
// R13: After reset every source covered here sits at priority level 4.
// R14: Writes to unused bits are ignored and disturb no field or arbitration state.
// R15: Each field feeds arbitration continuously, so a write counts from the cycle after it.
`ifndef IPBU_CFG_SVH
`define IPBU_CFG_SVH

`define IPBU_NUM_SRC    21
`define IPBU_PRIO_RST   3'b100
`define IPBU_PRIO_OFF   3'b000
// Register indices; byte address is four times the index
`define IPBU_IDX_11     3'd0
`define IPBU_IDX_12     3'd1
`define IPBU_IDX_13     3'd2
`define IPBU_IDX_14     3'd3
`define IPBU_IDX_15     3'd4
`define IPBU_IDX_16     3'd5
`define IPBU_IDX_STAT   3'd6
`define IPBU_IDX_LAST   3'd6
// Field positions within a register
`define IPBU_LSB_F3     12
`define IPBU_LSB_F2     8
`define IPBU_LSB_F1     4
`define IPBU_LSB_F0     0
`define IPBU_BYTE_HI    1
`define IPBU_BYTE_LO    0
// Address decode
`define IPBU_ADDR_W     12
`define IPBU_IDX_MSB    4
`define IPBU_IDX_LSB    2

`endif

//--- logic/ipbu_pkg.sv
// Types shared by the upper priority bank modules
`default_nettype none
package ipbu_pkg;
    typedef logic [2:0]  ipbu_prio_t;
    typedef logic [20:0] ipbu_src_vec_t;
    typedef logic [2:0]  ipbu_idx_t;
    typedef logic [31:0] ipbu_word_t;
endpackage : ipbu_pkg
`default_nettype wire

//--- logic/ipbu_regbus_if.sv
// Internal register access path between the APB slave and the field bank
`timescale 1ns/1ps
`default_nettype none
interface ipbu_regbus_if;
    import ipbu_pkg::*;
    logic       wr_stb;
    ipbu_idx_t  idx;
    logic [1:0] wstrb;
    logic [15:0] wdata;
    ipbu_word_t rdata;

    modport slave (output wr_stb, output idx, output wstrb, output wdata, input rdata);
    modport bank  (input wr_stb, input idx, input wstrb, input wdata, output rdata);
endinterface : ipbu_regbus_if
`default_nettype wire

//--- logic/ipbu_apb_slave.sv
// APB slave front end: decode, zero-wait answer, registered read data
`timescale 1ns/1ps
`default_nettype none
`include "ipbu_cfg.svh"
module ipbu_apb_slave (
    input  wire logic                      clk_sys,
    input  wire logic                      srst,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [`IPBU_ADDR_W-1:0]   paddr,
    input  wire logic [31:0]               pwdata,
    input  wire logic [3:0]                pstrb,
    output var  ipbu_pkg::ipbu_word_t      prdata,
    output logic                           pready,
    output logic                           pslverr,
    ipbu_regbus_if.slave                   rbus
);
    import ipbu_pkg::*;

    logic hit;

    // Word aligned and inside the map; anything else answers with an error
    assign hit = (paddr[1:0] == 2'b00)
              && (paddr[`IPBU_ADDR_W-1:`IPBU_IDX_MSB+1] == '0)
              && (paddr[`IPBU_IDX_MSB:`IPBU_IDX_LSB] <= `IPBU_IDX_LAST);

    assign rbus.idx   = paddr[`IPBU_IDX_MSB:`IPBU_IDX_LSB];
    assign rbus.wdata = pwdata[15:0];
    assign rbus.wstrb = pstrb[1:0];

    // Zero wait states: every access phase completes on its first edge
    assign pready  = psel & penable;
    assign pslverr = psel & penable & ~hit;
    // Unmapped writes never reach the bank
    assign rbus.wr_stb = psel & penable & pwrite & hit; // R14

    // Read data captured in the setup cycle so it leaves a flop
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= hit ? rbus.rdata : 32'h0000_0000;
        end
    end
endmodule : ipbu_apb_slave
`default_nettype wire

//--- logic/ipbu_prio_field.sv
// One 3-bit priority field with its source request gate
`timescale 1ns/1ps
`default_nettype none
`include "ipbu_cfg.svh"
module ipbu_prio_field (
    input  wire logic                 clk_sys,
    input  wire logic                 srst,
    input  wire logic                 wr_en,
    input  wire ipbu_pkg::ipbu_prio_t wr_val,
    input  wire logic                 pending,
    output var  ipbu_pkg::ipbu_prio_t level,
    output logic                      request
);
    import ipbu_pkg::*;

    // Field store; reset parks the source at the middle level
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            level <= `IPBU_PRIO_RST; // R4 R13
        end else if (wr_en) begin
            level <= wr_val; // R12
        end
    end

    // Code is the level itself, so 1..7 map straight through; zero silences the source
    assign request = pending && (level != `IPBU_PRIO_OFF); // R1 R2 R3 R15
endmodule : ipbu_prio_field
`default_nettype wire

//--- dv/ipbu_monitor.sv
// Checker of the APB answer and of the priority field behaviour
`timescale 1ns/1ps
`default_nettype none
module ipbu_monitor (
    input wire logic                    clk_sys,
    input wire logic                    srst,
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pwrite,
    input wire logic [11:0]             paddr,
    input wire logic [31:0]             pwdata,
    input wire logic [3:0]              pstrb,
    input wire ipbu_pkg::ipbu_word_t    prdata,
    input wire logic                    pready,
    input wire logic                    pslverr,
    input wire ipbu_pkg::ipbu_src_vec_t src_pending,
    input wire ipbu_pkg::ipbu_src_vec_t src_request,
    input wire ipbu_pkg::ipbu_prio_t    timer6_prio,
    input wire ipbu_pkg::ipbu_prio_t    pwm_fault_b_prio
);
    import ipbu_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    // Taken writes into the first and the last register
    sequence s_wr11; psel && penable && pwrite && paddr == 12'h000 && pstrb[1]; endsequence
    sequence s_wr16; psel && penable && pwrite && paddr == 12'h014 && pstrb[0]; endsequence
    property p_ready; psel && penable |-> pready; endproperty
    property p_rst; $fell(srst) |-> timer6_prio == 3'b100 && pwm_fault_b_prio == 3'b100; endproperty
    property p_off; timer6_prio == 3'b000 |-> !src_request[0]; endproperty
    property p_req; timer6_prio != 3'b000 |-> src_request[0] == src_pending[0]; endproperty
    property p_wr11; s_wr11 |=> timer6_prio == $past(pwdata[14:12]); endproperty
    property p_wr16; s_wr16 |=> pwm_fault_b_prio == $past(pwdata[2:0]); endproperty
    property p_hold; !(psel && penable && pwrite) |=> $stable(timer6_prio); endproperty
    property p_upper; psel && penable && !pwrite && paddr < 12'h018 |-> prdata[31:15] == 17'h0_0000; endproperty
    property p_err; psel && penable && (paddr[1:0] != 2'b00 || paddr > 12'h018) |-> pslverr; endproperty
    a_ready: assert property (p_ready) else $error("access phase without zero-wait answer");
    a_rst: assert property (p_rst) else $error("field not at level four after reset");
    a_off: assert property (p_off) else $error("disabled source still requests");
    a_req: assert property (p_req) else $error("enabled source request not passed");
    a_wr11: assert property (p_wr11) else $error("timer6 field not updated by write");
    a_wr16: assert property (p_wr16) else $error("fault B field not updated by write");
    a_hold: assert property (p_hold) else $error("field changed without a write");
    a_upper: assert property (p_upper) else $error("upper read bits not zero");
    a_err: assert property (p_err) else $error("bad address not refused");
endmodule : ipbu_monitor
bind ipbu_top ipbu_monitor i_mon (.clk_sys, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .src_pending, .src_request, .timer6_prio, .pwm_fault_b_prio);
`default_nettype wire

//--- dv/ipbu_arb_model.sv
// Arbitration stand-in: highest level among the requesting sources
`timescale 1ns/1ps
`default_nettype none
module ipbu_arb_model (
    input  wire ipbu_pkg::ipbu_src_vec_t src_request,
    input  wire ipbu_pkg::ipbu_prio_t    lvl [21],
    output var  ipbu_pkg::ipbu_prio_t    win_level
);
    import ipbu_pkg::*;
    // Zero means nothing wins; it trusts the request gate, so a disabled source is never seen
    always_comb begin
        win_level = 3'h0;
        for (int i = 0; i < 21; i++) begin
            if (src_request[i] && lvl[i] > win_level) win_level = lvl[i];
        end
    end
endmodule : ipbu_arb_model
`default_nettype wire

//--- dv/tb_top.sv
// Self-checking bench of the upper priority bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ipbu_pkg::*;
    logic          clk_sys, srst, psel, penable, pwrite, pready, pslverr;
    logic [11:0]   paddr;
    logic [31:0]   pwdata;
    logic [3:0]    pstrb;
    ipbu_word_t    prdata;
    ipbu_src_vec_t src_pending, src_request;
    ipbu_prio_t    lvl [21];
    ipbu_prio_t    win;
    logic [33:0]   exp_q [$];
    logic [33:0]   cur;
    logic [15:0]   shadow [6];
    int            n_mismatch = 0;
    int            tests_run = 0;
    // Register and field position of each source, in port order
    int f_reg [21] = '{0, 0, 0, 1, 1, 1, 1, 2, 2, 2, 2, 3, 3, 3, 3, 4, 4, 4, 5, 5, 5};
    int f_lsb [21] = '{12, 8, 0, 12, 8, 4, 0, 12, 8, 4, 0, 12, 8, 4, 0, 12, 4, 0, 8, 4, 0};
    ipbu_top i_dut (.clk_sys, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .src_pending, .src_request, .timer6_prio(lvl[0]), .dma_ch4_done_prio(lvl[1]),
        .out_cmp8_prio(lvl[2]), .timer8_prio(lvl[3]), .i2c_b_master_prio(lvl[4]), .i2c_b_slave_prio(lvl[5]),
        .timer7_prio(lvl[6]), .can_b_rx_ready_prio(lvl[7]), .ext_irq4_prio(lvl[8]), .ext_irq3_prio(lvl[9]),
        .timer9_prio(lvl[10]), .codec_port_error_prio(lvl[11]), .quad_decoder_prio(lvl[12]),
        .motor_pwm_prio(lvl[13]), .can_b_event_prio(lvl[14]), .pwm_fault_a_prio(lvl[15]),
        .dma_ch5_done_prio(lvl[16]), .codec_port_event_prio(lvl[17]), .uart_b_error_prio(lvl[18]),
        .uart_a_error_prio(lvl[19]), .pwm_fault_b_prio(lvl[20]));
    ipbu_arb_model i_arb (.src_request, .lvl, .win_level(win));
    // Word with one code in every field of a register
    function automatic logic [15:0] fill(int r, logic [2:0] c);
        logic [15:0] w;
        w = 16'h0000;
        for (int i = 0; i < 21; i++) if (f_reg[i] == r) w[f_lsb[i] +: 3] = c;
        return w;
    endfunction : fill
    task automatic chk(logic ok);
        tests_run++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("Error at %0t: output mismatch", $time);
        end
    endtask : chk
    // One APB transfer; the expected answer is noted before the request goes out
    task automatic apb(logic wr, logic [11:0] a, logic [15:0] d, logic [3:0] s, logic [31:0] e, logic err);
        exp_q.push_back({wr, err, e});
        @(posedge clk_sys);
        {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, wr, a, 16'h0000, d, s};
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        // Wait for the answer however long it takes; only the watchdog ends a hang
        while (pready !== 1'b1) @(posedge clk_sys);
        {psel, penable} <= 2'b00;
    endtask : apb
    // Write a register and keep the bench copy, lane by lane, implemented bits only
    task automatic wr(int r, logic [15:0] d, logic [3:0] s);
        logic [15:0] m;
        m = fill(r, 3'b111);
        for (int b = 0; b < 2; b++) if (s[b]) shadow[r][8 * b +: 8] = d[8 * b +: 8] & m[8 * b +: 8];
        apb(1'b1, 12'(r * 4), d, s, 32'h0000_0000, 1'b0);
    endtask : wr
    task automatic chk_lv();
        @(negedge clk_sys);
        for (int i = 0; i < 21; i++) chk(lvl[i] === shadow[f_reg[i]][f_lsb[i] +: 3]);
    endtask : chk_lv
    task automatic do_reset();
        srst <= 1'b1;
        repeat (5) @(posedge clk_sys);
        srst <= 1'b0;
        for (int r = 0; r < 6; r++) shadow[r] = fill(r, 3'b100);
    endtask : do_reset
    task automatic rd_all();
        for (int r = 0; r < 6; r++) apb(1'b0, 12'(r * 4), 16'h0000, 4'h0, {16'h0000, shadow[r]}, 1'b0);
    endtask : rd_all
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : stop_test
    // Watcher: each completed transfer takes the oldest note
    always @(posedge clk_sys) begin
        if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
            cur = exp_q.pop_front();
            tests_run++;
            if (pslverr !== cur[32] || (!cur[33] && prdata !== cur[31:0])) begin
                n_mismatch++;
                $display("Error at %0t: answer at %h mismatch", $time, paddr);
            end
        end
    end
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    initial begin
        #(100 * 20000);
        n_mismatch++;
        stop_test();
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        srst = 1'b1;
        void'($urandom(18));
        src_pending = 21'($urandom);
        do_reset();
        rd_all();
        chk_lv();
        // All ones, then random data, then random lanes
        for (int n = 0; n < 3; n++) begin
            for (int r = 0; r < 6; r++) wr(r, n == 0 ? 16'hffff : 16'($urandom), n == 2 ? 4'($urandom) : 4'hf);
            chk_lv();
            rd_all();
        end
        // Every code in every field, with pending sources changing
        for (int c = 0; c < 8; c++) begin
            src_pending <= 21'($urandom) | 21'h00_0001;
            for (int r = 0; r < 6; r++) wr(r, fill(r, 3'(c)), 4'h3);
            chk_lv();
            chk(src_request === (c != 0 ? src_pending : 21'h00_0000));
            chk(win === 3'(c));
            apb(1'b0, 12'h018, 16'h0000, 4'h0, {11'h000, c != 0 ? src_pending : 21'h00_0000}, 1'b0);
        end
        // Refused and ignored accesses leave the fields alone
        apb(1'b0, 12'h01c, 16'h0000, 4'h0, 32'h0000_0000, 1'b1);
        apb(1'b1, 12'h002, 16'h0000, 4'hf, 32'h0000_0000, 1'b1);
        apb(1'b1, 12'h018, 16'h0000, 4'hf, 32'h0000_0000, 1'b0);
        chk_lv();
        do_reset();
        rd_all();
        chk_lv();
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
